// File: design/cdiv_top.sv
// Divide-by-three/five clock divider with synchronous enable and fail-safe input
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Divide input clock by three when select low, by five when high.
// - Undriven select, enable and reset pins read as logic high.
// - Disabled output holds true output low, complement high.
// - Enable change applies after one input rising then one falling edge.
// - Low reset pin forces outputs immediately, without input clock edges.
// - Collapsed input clock keeps the output static; a missing one may still count one last falling edge first.
// - Undriven differential input settles to a defined level, no clocking.
// - Divide-by-three output high time within 46 to 54 percent, both edges.
// - Divide-by-five output high time within 47 to 53 percent.
module cdiv_top (
	// System
	input wire logic sys_clk,
	input wire logic nrst,
	// Differential input clock, sampled on sys_clk
	input wire logic clk_in_p,
	input wire logic clk_in_n,
	input wire logic clk_in_oe,
	// Control pins, each with a drive flag for the pull-up
	input wire logic ratio_sel,
	input wire logic ratio_sel_oe,
	input wire logic out_en,
	input wire logic out_en_oe,
	input wire logic force_low_n,
	input wire logic force_low_n_oe,
	// Differential output
	output logic clk_out_q,
	output logic clk_out_n_q
);
	// ----------------------------------------
	// Control pin pull-ups
	// ----------------------------------------
	logic [cdiv_pkg::CDIV_NPINS-1:0] pin_drv;
	logic [cdiv_pkg::CDIV_NPINS-1:0] pin_oe;
	logic [cdiv_pkg::CDIV_NPINS-1:0] pin_lvl;
	assign pin_drv = {force_low_n, out_en, ratio_sel};
	assign pin_oe = {force_low_n_oe, out_en_oe, ratio_sel_oe};
	genvar gi;
	generate
		for (gi = 0; gi < cdiv_pkg::CDIV_NPINS; gi++) begin : g_pull
			cdiv_pullup u_pull (
				.pin_drv(pin_drv[gi]),
				.pin_oe(pin_oe[gi]),
				.lvl(pin_lvl[gi])
			);
		end
	endgenerate
	wire sel_lvl = pin_lvl[cdiv_pkg::CDIV_PIN_SEL];
	wire en_lvl = pin_lvl[cdiv_pkg::CDIV_PIN_EN];
	wire force_low_lvl_n = pin_lvl[cdiv_pkg::CDIV_PIN_FLN];
	// Force pin joins the reset so it acts with no clock at all
	wire arst_n = nrst & force_low_lvl_n;

	// ----------------------------------------
	// Input clock resolve and edge detect
	// ----------------------------------------
	// Open input rests at a fixed differential level, never mid-swing
	wire in_p = clk_in_oe ? clk_in_p : cdiv_pkg::CDIV_IN_OPEN_P;
	wire in_n = clk_in_oe ? clk_in_n : cdiv_pkg::CDIV_IN_OPEN_N;
	// Equal legs model a swing below threshold; edges are then ignored
	wire in_valid = in_p ^ in_n;
	// Raised while the input is unusable; counter and enable then freeze
	wire input_loss_guard = ~in_valid;
	logic in_prev_q;
	wire in_rise = in_valid & in_p & ~in_prev_q;
	wire in_fall = in_valid & ~in_p & in_prev_q;
	wire in_edge = in_rise | in_fall;

	// Previous level only moves on a valid input, so noise cannot fake edges
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_prev_q <= cdiv_pkg::CDIV_IN_OPEN_P;
		end else if (in_valid) begin
			in_prev_q <= in_p;
		end
	end

	// ----------------------------------------
	// Synchronous enable: caught on rise, applied on fall
	// ----------------------------------------
	logic en_rise_q;
	logic en_act_q;
	logic en_act_d;
	assign en_act_d = in_fall ? en_rise_q : en_act_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_rise_q <= cdiv_pkg::CDIV_EN_RST;
			en_act_q <= cdiv_pkg::CDIV_EN_RST;
		end else begin
			en_rise_q <= in_rise ? en_lvl : en_rise_q;
			en_act_q <= en_act_d;
		end
	end

	// ----------------------------------------
	// Edge counter and output toggle
	// ----------------------------------------
	// Counting both edges gives an odd ratio with an exact half duty
	logic [2:0] edge_cnt_q;
	logic [2:0] edge_cnt_d;
	logic [2:0] div_last;
	logic wrap;
	logic clk_out_d;
	assign div_last = sel_lvl ? cdiv_pkg::CDIV_DIV5_LAST : cdiv_pkg::CDIV_DIV3_LAST;
	assign wrap = in_edge && (edge_cnt_q >= div_last);
	assign edge_cnt_d = !en_act_d ? cdiv_pkg::CDIV_CNT_RST :
		wrap ? cdiv_pkg::CDIV_CNT_RST :
		in_edge ? 3'(edge_cnt_q + 3'h1) : edge_cnt_q;
	// Disabling mid-pulse cuts only at a falling input edge
	assign clk_out_d = !en_act_d ? cdiv_pkg::CDIV_OUT_RST :
		wrap ? ~clk_out_q : clk_out_q;

	// Both legs from one next value so they can never disagree
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_cnt_q <= cdiv_pkg::CDIV_CNT_RST;
			clk_out_q <= cdiv_pkg::CDIV_OUT_RST;
			clk_out_n_q <= ~cdiv_pkg::CDIV_OUT_RST;
		end else begin
			edge_cnt_q <= edge_cnt_d;
			clk_out_q <= clk_out_d;
			clk_out_n_q <= ~clk_out_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_compl;
		@(posedge sys_clk) disable iff (!arst_n) clk_out_q != clk_out_n_q;
	endproperty
	a_compl: assert property (p_compl) else $error("output legs not complementary");

	property p_disabled_low;
		@(posedge sys_clk) disable iff (!arst_n) !en_act_q |-> !clk_out_q && clk_out_n_q;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("output high while disabled");

	property p_en_on_fall;
		@(posedge sys_clk) disable iff (!arst_n)
			$changed(en_act_q) |-> $past(in_fall) && en_act_q == $past(en_rise_q);
	endproperty
	a_en_on_fall: assert property (p_en_on_fall) else $error("enable moved off a falling edge");

	property p_en_caught_rise;
		@(posedge sys_clk) disable iff (!arst_n) $changed(en_rise_q) |-> $past(in_rise);
	endproperty
	a_en_caught_rise: assert property (p_en_caught_rise) else $error("enable caught off rise");

	property p_failsafe;
		@(posedge sys_clk) disable iff (!arst_n) input_loss_guard |=> $stable(clk_out_q);
	endproperty
	a_failsafe: assert property (p_failsafe) else $error("output moved on invalid input");

	property p_ratio;
		@(posedge sys_clk) disable iff (!arst_n)
			$changed(clk_out_q) && en_act_q |-> $past(edge_cnt_q) == $past(div_last);
	endproperty
	a_ratio: assert property (p_ratio) else $error("toggle at wrong edge count");

	property p_force_low;
		@(posedge sys_clk) disable iff (!nrst) !force_low_lvl_n |-> !clk_out_q && clk_out_n_q;
	endproperty
	a_force_low: assert property (p_force_low) else $error("force low not obeyed");

	property p_force_wins;
		@(posedge sys_clk) disable iff (!nrst)
			!force_low_lvl_n && en_lvl |-> !clk_out_q && !en_act_q;
	endproperty
	a_force_wins: assert property (p_force_wins) else $error("enable beat force low");

	property p_pull_sel;
		@(posedge sys_clk) disable iff (!arst_n)
			!ratio_sel_oe |-> div_last == cdiv_pkg::CDIV_DIV5_LAST;
	endproperty
	a_pull_sel: assert property (p_pull_sel) else $error("open select not divide by five");

	property p_open_input;
		@(posedge sys_clk) disable iff (!arst_n) (!clk_in_oe) [*2] |-> !in_edge;
	endproperty
	a_open_input: assert property (p_open_input) else $error("open input clocked");

	property p_pull_en;
		@(posedge sys_clk) disable iff (!arst_n) !out_en_oe |-> en_lvl;
	endproperty
	a_pull_en: assert property (p_pull_en) else $error("open enable read low");

	property p_pull_force;
		@(posedge sys_clk) disable iff (!nrst) !force_low_n_oe |-> force_low_lvl_n;
	endproperty
	a_pull_force: assert property (p_pull_force) else $error("open force pin low");

	property p_open_level;
		@(posedge sys_clk) disable iff (!arst_n) !clk_in_oe |-> in_valid && !in_p;
	endproperty
	a_open_level: assert property (p_open_level) else $error("open input level");

	property p_dis_cnt;
		@(posedge sys_clk) disable iff (!arst_n)
			!en_act_q |-> edge_cnt_q == cdiv_pkg::CDIV_CNT_RST;
	endproperty
	a_dis_cnt: assert property (p_dis_cnt) else $error("count while disabled");

	property p_still;
		@(posedge sys_clk) disable iff (!arst_n) !in_edge |=> $stable(clk_out_q);
	endproperty
	a_still: assert property (p_still) else $error("output moved without edge");

	// ----------------------------------------
	// Coverage of the main scenarios
	// ----------------------------------------
	c_div3: cover property (@(posedge sys_clk) disable iff (!arst_n)
		!sel_lvl && en_act_q && $rose(clk_out_q));
	c_div5: cover property (@(posedge sys_clk) disable iff (!arst_n)
		sel_lvl && en_act_q && $fell(clk_out_q));
	c_disable: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(en_act_q));
	c_failsafe: cover property (@(posedge sys_clk) disable iff (!arst_n)
		en_act_q && input_loss_guard);
	c_force: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(force_low_lvl_n));
endmodule
`default_nettype wire

// File: common/cdiv_pkg.sv
// Constants shared by the divide-by-three/five clock divider
package cdiv_pkg;
	// ----------------------------------------
	// Divide ratios, counted in input clock edges (both edges)
	// ----------------------------------------
	localparam logic [2:0] CDIV_DIV3_LAST = 3'h2; // Toggle after three half periods
	localparam logic [2:0] CDIV_DIV5_LAST = 3'h4; // Toggle after five half periods
	localparam logic [2:0] CDIV_CNT_RST = 3'h0;
	// ----------------------------------------
	// Reset and default levels
	// ----------------------------------------
	localparam logic CDIV_OUT_RST = 1'h0;    // True output low in reset
	localparam logic CDIV_EN_RST = 1'h0;     // Enable taken as off until first edges
	localparam logic CDIV_PULL_LVL = 1'h1;   // Undriven control pin reads high
	localparam logic CDIV_IN_OPEN_P = 1'h0;  // Open differential input rests low
	localparam logic CDIV_IN_OPEN_N = 1'h1;
	// Control pin indices for the pull-up array
	localparam int CDIV_NPINS = 3;
	localparam int CDIV_PIN_SEL = 0;
	localparam int CDIV_PIN_EN = 1;
	localparam int CDIV_PIN_FLN = 2;
endpackage

// File: design/cdiv_pullup.sv
// Weak pull-up model for an undriven control pin
`timescale 1ns/10ps
`default_nettype none
module cdiv_pullup (
	// Pin as driven from outside
	input wire logic pin_drv,
	input wire logic pin_oe,
	// Resolved level
	output logic lvl
);
	// Undriven pin defaults high, as the internal pull-up makes it
	assign lvl = pin_oe ? pin_drv : cdiv_pkg::CDIV_PULL_LVL;
endmodule
`default_nettype wire

// File: tb/cdiv_src.sv
// Upstream differential clock source model for the divider bench
`timescale 1ns/10ps
`default_nettype none
module cdiv_src (
	// Bench side
	input wire logic sys_clk,
	input wire logic [1:0] mode,
	input wire logic [2:0] half,
	// Differential legs and drive flag
	output logic p,
	output logic n,
	output logic oe
);
	logic [2:0] cnt;
	logic lvl;
	initial {p, n, oe, lvl, cnt} = 7'h30;
	// Mode 0 runs, 1 holds still, 2 shorts legs together, 3 releases the pins
	// Released or shorted legs keep changing so a stale level never looks valid
	always @(posedge sys_clk) begin
		#2;
		cnt = (mode == 2'h0 && cnt + 3'h1 < half) ? cnt + 3'h1 : 3'h0;
		if (mode == 2'h0 && cnt == 3'h0) lvl = ~lvl;
		oe = (mode != 2'h3);
		p = mode[1] ? ~p : lvl;
		n = (mode == 2'h2) ? p : ~p;
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the divide-by-three/five clock divider
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic sel = 1'b0, sel_oe = 1'b1, en = 1'b1, en_oe = 1'b1, fl_n = 1'b1, fl_oe = 1'b1;
	logic [1:0] mode = 2'h1;
	logic [2:0] half = 3'h2;
	logic p, n, oe, q, qn;
	logic q_prev = 1'b0;
	logic chk_on = 1'b0;
	logic exp_v[$];
	int exp_gap[$];
	int gap = 0, n_fail = 0, checks = 0, seed = 39075;
	always #25 sys_clk = ~sys_clk;
	cdiv_src src (.sys_clk(sys_clk), .mode(mode), .half(half), .p(p), .n(n), .oe(oe));
	cdiv_top uut (.sys_clk(sys_clk), .nrst(nrst), .clk_in_p(p), .clk_in_n(n), .clk_in_oe(oe),
		.ratio_sel(sel), .ratio_sel_oe(sel_oe), .out_en(en), .out_en_oe(en_oe),
		.force_low_n(fl_n), .force_low_n_oe(fl_oe), .clk_out_q(q), .clk_out_n_q(qn));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask
	task automatic cmp_int(input int got, input int exp, input string what);
		checks++;
		if (got != exp) begin
			n_fail++;
			$display("ERROR %0t: %s got %0d want %0d", $time, what, got, exp);
		end
	endtask
	task automatic step();
		@(posedge sys_clk);
		#2;
	endtask
	// Bounded wait; running out is a mismatch and ends the run
	task automatic wait_q(input logic v, input int lim);
		while (q !== v && !(v === 1'bz && exp_v.size() == 0) && lim > 0) begin
			@(posedge sys_clk);
			#1;
			lim--;
		end
		if (lim == 0) cmp_bit(1'b0, 1'b1, "wait ran out");
		if (lim == 0) end_sim();
	endtask
	task automatic hold_chk(input logic v, input int k);
		repeat (k) begin
			@(posedge sys_clk);
			#1;
			cmp_bit(q, v, "static level");
		end
	endtask
	// Fresh reset, then five noted toggles; gap 0 skips the unknown first one
	task automatic run_ratio(input logic s, input logic s_oe, input int nr);
		step();
		chk_on = 1'b0;
		sel = s;
		sel_oe = s_oe;
		half = 3'h2 + 3'(($random(seed) & 32'h7fffffff) % 3);
		nrst = 1'b0;
		step();
		nrst = 1'b1;
		mode = 2'h0;
		exp_v = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		exp_gap = '{0, nr * int'(half), nr * int'(half), nr * int'(half), nr * int'(half)};
		chk_on = 1'b1;
		wait_q(1'bz, 300);
		chk_on = 1'b0;
	endtask
	// Watches every output edge; while chk_on is set, matches it to the oldest note or flags it stray
	always @(posedge sys_clk) begin
		#1;
		gap++;
		cmp_bit(q ^ qn, 1'b1, "complement leg");
		if (q !== q_prev && chk_on && exp_v.size() == 0) cmp_bit(1'b1, 1'b0, "stray edge");
		if (q !== q_prev && chk_on && exp_v.size() > 0) begin
			cmp_bit(q, exp_v.pop_front(), "output level");
			if (exp_gap[0] > 0) cmp_int(gap, exp_gap[0], "half period");
			void'(exp_gap.pop_front());
		end
		if (q !== q_prev) gap = 0;
		q_prev = q;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		#2;
		nrst = 1'b1;
		hold_chk(1'b0, 8);
		run_ratio(1'b0, 1'b1, 3);
		run_ratio(1'b1, 1'b1, 5);
		en_oe = 1'b0;
		run_ratio(1'b0, 1'b0, 5);
		step();
		fl_n = 1'b0;
		#2;
		cmp_bit(q, 1'b0, "forced true leg");
		cmp_bit(qn, 1'b1, "forced complement leg");
		hold_chk(1'b0, 40);
		step();
		{fl_oe, en_oe, en} = 3'h2;
		hold_chk(1'b0, 40);
		step();
		en = 1'b1;
		wait_q(1'b1, 100);
		step();
		en = 1'b0;
		wait_q(1'b0, 40);
		hold_chk(1'b0, 40);
		step();
		en = 1'b1;
		wait_q(1'b1, 100);
		step();
		mode = 2'h2;
		step();
		hold_chk(q, 40);
		step();
		mode = 2'h3;
		// Removal may count one last fall, so let it land before freezing
		step();
		step();
		hold_chk(q, 40);
		end_sim();
	end
endmodule
`default_nettype wire
